// ==== rtl/iom_maint_regs.sv ====
`timescale 1ns/1ns
`default_nettype none
module iom_maint_regs #(
    parameter int PP_COUNT = 20,
    parameter logic [7:0] ELEM_TYPE = 8'h5a,      // Arbitrary value
    parameter logic [7:0] ELEM_MODEL = 8'ha5,     // Arbitrary value
    parameter logic [15:0] ELEM_SERIAL = 16'h0001, // Arbitrary value
    parameter logic [63:0] OPTIONS = 64'hffffffff_ffffffff
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic funcValid,
    input wire logic [3:0] funcCode,
    input wire logic ctrlValid,
    input wire logic [15:0] ctrlWord,
    input wire logic wrValid,
    input wire logic [63:0] wrData,
    input wire logic rdReq,
    input wire logic [3:0] rdBytes,
    output logic rdValid,
    output logic [63:0] rdData,
    output logic summaryStatus,
    output iom_pkg::iom_state_t selState,
    input wire logic [PP_COUNT-1:0] ppError,
    input wire logic [iom_pkg::UNIT_ERR_COUNT-1:0] unitError,
    input wire logic [63:0] chanFault,
    input wire logic procHalt,
    input wire logic uncorrError,
    input wire logic envAlertPin,
    input wire logic longDeadstartPin,
    input wire logic barrelSwitchPin,
    input wire logic [3:0] ppSwitchPin,
    input wire logic [1:0] registerSelectBits,
    input wire logic [17:0] accReg,
    input wire logic [17:0] progAddrReg,
    input wire logic [17:0] qReg,
    input wire logic [17:0] kReg
);
    import iom_pkg::*;

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (PP_COUNT < 1 || PP_COUNT > PP_MAX) begin : g_bad_count
        $error("PP_COUNT must lie between 1 and 20");
    end

    typedef struct packed {
        iom_state_t mode;
        logic [7:0] addr;
        logic [63:0] mask;
        logic rdValid;
        logic [63:0] rdData;
        logic summary;
    } iom_core_t;

    iom_core_t state;
    iom_core_t next_state;
    logic [63:0] fault1;
    logic [63:0] faultSet;
    logic [63:0] faultClr;
    logic [63:0] maskedSrc;
    logic summaryNow;
    logic [INTREG_WIDTH-1:0] intReg;
    logic [6:0] pinLevel;
    logic envAlert;
    logic longDeadstart;
    logic barrelSwitch;
    logic [3:0] ppSwitch;
    logic selWrite;

    // ------------------------------------------------------------
    // Pin inputs through the three-stage filter
    // ------------------------------------------------------------
    iom_sync #(
        .WIDTH(7)
    ) u_pins (
        .clock(clock),
        .rst(rst),
        .pinIn({ppSwitchPin, barrelSwitchPin, longDeadstartPin, envAlertPin}),
        .level(pinLevel)
    );

    assign envAlert = pinLevel[0];
    assign longDeadstart = pinLevel[1];
    assign barrelSwitch = pinLevel[2];
    assign ppSwitch = pinLevel[6:3];

    // ------------------------------------------------------------
    // Fault status one, error sources and clearing
    // ------------------------------------------------------------
    // Processors fill groups of five, stepping eight bits per group
    always_comb begin
        faultSet = '0;
        for (int k = 0; k < PP_COUNT; k++) begin
            faultSet[PP_FIRST_BIT + PP_GROUP_STRIDE * (k / PP_GROUP) + k % PP_GROUP] = ppError[k];
        end
        for (int u = 0; u < UNIT_ERR_COUNT; u++) begin
            faultSet[UNIT_ERR_POS[u]] = unitError[u];
        end
    end

    assign selWrite = state.mode == ST_READY && wrValid && !funcValid;
    // Writing a one clears that fault; a fresh error still wins
    assign faultClr = (selWrite && state.addr == ADDR_FAULT1) ? wrData : 64'h0;

    iom_sticky #(
        .WIDTH(64),
        .KEEP(FS1_BITS),
        .RESET(FAULT1_RESET)
    ) u_fault1 (
        .clock(clock),
        .rst(rst),
        .setBits(faultSet),
        .clrBits(faultClr),
        .value(fault1)
    );

    // ------------------------------------------------------------
    // Summary status and internal register view
    // ------------------------------------------------------------
    // Masked sources stay recorded but drop out of the summary
    assign maskedSrc = ((fault1 & PP_BITS) | (chanFault & CHAN_BITS)) & ~state.mask;
    assign summaryNow = (|maskedSrc) || (|(fault1 & FS1_OTHER_BITS));

    always_comb begin
        case (registerSelectBits)
            2'b00: intReg = accReg;
            2'b01: intReg = progAddrReg;
            2'b10: intReg = qReg;
            2'b11: intReg = kReg;
            default: intReg = '0;
        endcase
    end

    // ------------------------------------------------------------
    // Read data assembly
    // ------------------------------------------------------------
    function automatic logic [63:0] readWord(input logic [7:0] addr, input logic multi, input logic sumBit,
                                             input logic [63:0] maskReg);
        logic [63:0] w;
        w = 64'h0;
        case (addr)
            ADDR_SUMMARY: begin
                w[SUM_STATUS_BIT] = sumBit;
                w[SUM_HALT_BIT] = procHalt;
                w[SUM_UNCORR_BIT] = uncorrError;
                w[SUM_ENV_BIT] = envAlert;
                if (multi) begin
                    for (int b = 0; b < 64 / BYTE_WIDTH; b++) begin
                        w[b * BYTE_WIDTH + SUM_STATUS_BIT % BYTE_WIDTH] = sumBit;
                        w[b * BYTE_WIDTH + SUM_HALT_BIT % BYTE_WIDTH] = procHalt;
                    end
                end
            end
            ADDR_IDENT: begin
                w[ID_TYPE_LSB +: 8] = ELEM_TYPE;
                w[ID_MODEL_LSB +: 8] = ELEM_MODEL;
                w[ID_SERIAL_LSB +: 16] = ELEM_SERIAL;
            end
            ADDR_OPTIONS: w = OPTIONS & OPT_BITS;
            ADDR_MASK: w = maskReg;
            ADDR_STATUS: begin
                w[INTREG_LSB +: INTREG_WIDTH] = intReg;
                w[DEADSTART_BIT] = longDeadstart;
                w[BARREL_SW_BIT] = barrelSwitch;
                w[PP_SW_LSB +: PP_SW_WIDTH] = ppSwitch;
            end
            ADDR_FAULT1: w = fault1;
            default: w = 64'h0;
        endcase
        return w;
    endfunction : readWord

    // ------------------------------------------------------------
    // Selection sequence, register writes and read answers
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_state.rdValid = 1'b0;
        next_state.summary = summaryNow;
        if (funcValid) begin
            // A select function word restarts selection; any other function code drops it
            if (funcCode == FUNC_SELECT_A || funcCode == FUNC_SELECT_B) begin
                next_state.mode = ST_WAIT_CTRL;
            end else begin
                next_state.mode = ST_IDLE;
            end
        end else begin
            case (state.mode)
                ST_IDLE: next_state.mode = ST_IDLE;
                ST_WAIT_CTRL: begin
                    if (ctrlValid) begin
                        next_state.mode = ST_READY;
                        next_state.addr = ctrlWord[7:0];
                    end
                end
                ST_READY: begin
                    if (wrValid && state.addr == ADDR_MASK) begin
                        next_state.mask = wrData & MASK_BITS;
                    end
                    if (rdReq) begin
                        next_state.rdValid = 1'b1;
                        next_state.rdData = readWord(state.addr, rdBytes > 4'h1, summaryNow, state.mask);
                    end
                end
                default: next_state.mode = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state.mode <= ST_IDLE;
            state.addr <= 8'h00;
            state.mask <= MASK_RESET;
            state.rdValid <= 1'b0;
            state.rdData <= 64'h0;
            state.summary <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    assign rdValid = state.rdValid;
    assign rdData = state.rdData;
    assign summaryStatus = state.summary;
    assign selState = state.mode;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence armSeq;
        funcValid && (funcCode == FUNC_SELECT_A || funcCode == FUNC_SELECT_B);
    endsequence

    sequence ctrlSeq;
        !funcValid && ctrlValid;
    endsequence

    // The channel leaves one quiet cycle between function and control word
    sequence ctrlGap;
        !funcValid && !ctrlValid;
    endsequence

    sequence readAt(logic [7:0] a);
        state.mode == ST_READY && !funcValid && rdReq && state.addr == a;
    endsequence

    chk_select_sequence: assert property (armSeq ##1 ctrlGap ##1 ctrlSeq
        |=> selState == ST_READY && state.addr == $past(ctrlWord[7:0]))
        else $error("control word after function did not select register");

    chk_summary_layout: assert property (readAt(ADDR_SUMMARY) |=> rdValid && !rdData[62]
        && rdData[SUM_STATUS_BIT] == $past(summaryNow) && rdData[SUM_ENV_BIT] == $past(envAlert)
        && rdData[SUM_HALT_BIT] == $past(procHalt) && rdData[SUM_UNCORR_BIT] == $past(uncorrError))
        else $error("summary register fields wrong");

    chk_summary_dup: assert property (readAt(ADDR_SUMMARY) and rdBytes > 4'h1
        |=> rdData[3] == rdData[59] && rdData[4] == rdData[60] && rdData[27] == rdData[59] && rdData[12] == rdData[60])
        else $error("summary bits not repeated per byte");

    chk_ident_value: assert property (readAt(ADDR_IDENT)
        |=> rdData == {ELEM_SERIAL, ELEM_MODEL, ELEM_TYPE, 32'h0})
        else $error("identifier read wrong");

    chk_options_value: assert property (readAt(ADDR_OPTIONS) |=> rdData == (OPTIONS & OPT_BITS))
        else $error("options read wrong");

    chk_mask_write: assert property (state.mode == ST_READY && !funcValid && wrValid
        && state.addr == ADDR_MASK |=> state.mask == ($past(wrData) & MASK_BITS))
        else $error("mask write not stored");

    chk_status_view: assert property (readAt(ADDR_STATUS) |=> rdData[55:38] == $past(intReg)
        && rdData[63:60] == $past(ppSwitch) && rdData[56] == $past(longDeadstart))
        else $error("status register view wrong");

    chk_status_switch: assert property (readAt(ADDR_STATUS) |=> rdData[59] == $past(barrelSwitch)
        && rdData[58:57] == 2'b00 && rdData[37:0] == 38'h0)
        else $error("status switch fields wrong");

    chk_pp_capture: assert property (|ppError
        |=> (fault1 & $past(faultSet) & PP_BITS) == ($past(faultSet) & PP_BITS))
        else $error("processor error not recorded");

    // A clear in the cycle after the error may legally drop the bit again
    chk_unit_capture: assert property (unitError[6]
        |=> fault1[39] ##1 (fault1[39] || $past(faultClr[39])))
        else $error("unit error not recorded");

    chk_read_refused: assert property (!(state.mode == ST_READY && !funcValid && rdReq) |=> !rdValid)
        else $error("read answered outside selection");

    chk_unused_zero: assert property ((fault1 & ~FS1_BITS) == 64'h0
        && (state.mask & ~MASK_BITS) == 64'h0)
        else $error("unassigned bit set");

    chk_mask_blocks: assert property ((maskedSrc == 64'h0) && ((fault1 & FS1_OTHER_BITS) == 64'h0)
        |=> !summaryStatus)
        else $error("masked fault reached summary");

    chk_fault_summary: assert property ((fault1 & PP_BITS & ~state.mask) != 64'h0 |=> summaryStatus)
        else $error("unmasked fault missing from summary");

endmodule : iom_maint_regs
`default_nettype wire

// ==== rtl/iom_pkg.sv ====
package iom_pkg;

    // ------------------------------------------------------------
    // Register addresses on the maintenance channel
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_SUMMARY = 8'h00;
    localparam logic [7:0] ADDR_IDENT = 8'h10;
    localparam logic [7:0] ADDR_OPTIONS = 8'h12;
    localparam logic [7:0] ADDR_MASK = 8'h18;
    localparam logic [7:0] ADDR_STATUS = 8'h40;
    localparam logic [7:0] ADDR_FAULT1 = 8'h80;

    // ------------------------------------------------------------
    // Function codes that arm register selection
    // ------------------------------------------------------------
    localparam logic [3:0] FUNC_SELECT_A = 4'h4;
    localparam logic [3:0] FUNC_SELECT_B = 4'h5;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SUM_STATUS_BIT = 59;
    localparam int SUM_HALT_BIT = 60;
    localparam int SUM_UNCORR_BIT = 61;
    localparam int SUM_ENV_BIT = 63;
    localparam int BYTE_WIDTH = 8;
    localparam int ID_TYPE_LSB = 32;
    localparam int ID_MODEL_LSB = 40;
    localparam int ID_SERIAL_LSB = 48;
    localparam int INTREG_LSB = 38;
    localparam int INTREG_WIDTH = 18;
    localparam int DEADSTART_BIT = 56;
    localparam int BARREL_SW_BIT = 59;
    localparam int PP_SW_LSB = 60;
    localparam int PP_SW_WIDTH = 4;
    localparam int PP_FIRST_BIT = 3;
    localparam int PP_GROUP = 5;
    localparam int PP_GROUP_STRIDE = 8;
    localparam int PP_MAX = 20;
    localparam int UNIT_ERR_COUNT = 7;
    localparam int UNIT_ERR_POS [UNIT_ERR_COUNT] = '{32, 33, 34, 35, 36, 37, 39};

    // ------------------------------------------------------------
    // Implemented bit sets and reset values
    // ------------------------------------------------------------
    localparam logic [63:0] OPT_BITS = 64'hf0f0fff5_fff00000;
    localparam logic [63:0] MASK_BITS = 64'hf8fff5ff_f8f8f8f8;
    localparam logic [63:0] PP_BITS = 64'h00000000_f8f8f8f8;
    localparam logic [63:0] CHAN_BITS = 64'hf8fff5ff_00000000;
    localparam logic [63:0] FS1_OTHER_BITS = 64'h000000bf_00000000;
    localparam logic [63:0] FS1_BITS = 64'h000000bf_f8f8f8f8;
    localparam logic [63:0] MASK_RESET = 64'h00000000_00000000;
    localparam logic [63:0] FAULT1_RESET = 64'h00000000_00000000;

    // ------------------------------------------------------------
    // Selection sequence states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT_CTRL = 2'b01,
        ST_READY = 2'b10
    } iom_state_t;

endpackage : iom_pkg

// ==== rtl/iom_sync.sv ====
`timescale 1ns/1ns
`default_nettype none
module iom_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] level
);
    import iom_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] out;
    } iom_sync_t;

    iom_sync_t state;
    iom_sync_t next_state;

    // Accept a bit only once stages two and three agree
    always_comb begin
        next_state = state;
        next_state.s1 = pinIn;
        next_state.s2 = state.s1;
        next_state.s3 = state.s2;
        for (int i = 0; i < WIDTH; i++) begin
            if (state.s2[i] == state.s3[i]) begin
                next_state.out[i] = state.s3[i];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign level = state.out;
endmodule : iom_sync
`default_nettype wire

// ==== rtl/iom_sticky.sv ====
`timescale 1ns/1ns
`default_nettype none
module iom_sticky #(
    parameter int WIDTH = 64,
    parameter logic [WIDTH-1:0] KEEP = '1,
    parameter logic [WIDTH-1:0] RESET = '0
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [WIDTH-1:0] setBits,
    input wire logic [WIDTH-1:0] clrBits,
    output logic [WIDTH-1:0] value
);
    import iom_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] bits;
    } iom_sticky_t;

    iom_sticky_t state;
    iom_sticky_t next_state;

    // Set beats clear so an error landing on a clear is kept
    always_comb begin
        next_state = state;
        next_state.bits = ((state.bits & ~clrBits) | setBits) & KEEP;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state <= RESET;
        end else begin
            state <= next_state;
        end
    end

    assign value = state.bits;
endmodule : iom_sticky
`default_nettype wire

// ==== test/iom_master.sv ====
`timescale 1ns/1ns
`default_nettype none
module iom_master (
    input wire logic clock,
    output logic funcValid,
    output logic [3:0] funcCode,
    output logic ctrlValid,
    output logic [15:0] ctrlWord,
    output logic wrValid,
    output logic [63:0] wrData,
    output logic rdReq,
    output logic [3:0] rdBytes,
    input wire logic rdValid,
    input wire logic [63:0] rdData
);
    // Quiet channel at time zero
    initial begin
        funcValid = 1'b0;
        funcCode = 4'h0;
        ctrlValid = 1'b0;
        ctrlWord = 16'h0000;
        wrValid = 1'b0;
        wrData = 64'h0;
        rdReq = 1'b0;
        rdBytes = 4'h1;
    end
    // Released fields go inverted so a stale value never passes as valid
    task automatic send_func(input logic [3:0] code);
        @(posedge clock) #1;
        funcValid = 1'b1;
        funcCode = code;
        @(posedge clock) #1;
        funcValid = 1'b0;
        funcCode = ~code;
    endtask : send_func
    task automatic send_ctrl(input logic [15:0] word);
        @(posedge clock) #1;
        ctrlValid = 1'b1;
        ctrlWord = word;
        @(posedge clock) #1;
        ctrlValid = 1'b0;
        ctrlWord = ~word;
    endtask : send_ctrl
    // Function word first, then address in the second control byte
    task automatic select(input logic [3:0] code, input logic [7:0] addr, input logic [7:0] junk);
        send_func(code);
        send_ctrl({junk, addr});
    endtask : select
    task automatic write(input logic [63:0] data);
        @(posedge clock) #1;
        wrValid = 1'b1;
        wrData = data;
        @(posedge clock) #1;
        wrValid = 1'b0;
        wrData = ~data;
    endtask : write
    // Answer is taken at the edge after the request edge
    task automatic read(input logic [3:0] n, output logic got, output logic [63:0] data);
        @(posedge clock) #1;
        rdReq = 1'b1;
        rdBytes = n;
        @(posedge clock) #1;
        rdReq = 1'b0;
        rdBytes = ~n;
        got = rdValid;
        data = rdData;
    endtask : read
endmodule : iom_master
`default_nettype wire

// ==== test/tb_iom_maint_regs.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_iom_maint_regs;
    import iom_pkg::*;
    // ------------------------------------------------------------
    // Setup
    // ------------------------------------------------------------
    localparam logic [7:0] TYPE_P = 8'h3c; // Arbitrary value
    localparam logic [7:0] MODEL_P = 8'h7e; // Arbitrary value
    localparam logic [15:0] SERIAL_P = 16'h4321; // Arbitrary value
    localparam logic [63:0] OPTS_P = 64'h5a5ac3c3_0f0fffff;
    localparam int LIMIT = 20000;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic funcValid, ctrlValid, wrValid, rdReq, rdValid, summaryStatus, v;
    logic [3:0] funcCode, rdBytes, ppSwitchPin;
    logic [15:0] ctrlWord;
    logic [63:0] wrData, rdData, chanFault, d, expMask, expF1;
    iom_state_t selState;
    logic [19:0] ppError;
    logic [6:0] unitError;
    logic procHalt, uncorrError, envAlertPin, longDeadstartPin, barrelSwitchPin;
    logic [1:0] registerSelectBits;
    logic [17:0] accReg, progAddrReg, qReg, kReg;
    logic [7:0] addrs [7] = '{ADDR_SUMMARY, ADDR_IDENT, ADDR_OPTIONS, ADDR_MASK, ADDR_STATUS, ADDR_FAULT1, 8'h20};
    int errorCnt = 0;
    int checksDone = 0;
    int cycles = 0;
    int unsigned seed;

    always #2 clock = ~clock;

    iom_maint_regs #(.PP_COUNT(20), .ELEM_TYPE(TYPE_P), .ELEM_MODEL(MODEL_P), .ELEM_SERIAL(SERIAL_P),
        .OPTIONS(OPTS_P)) u_iom_maint_regs (.clock(clock), .rst(rst), .funcValid(funcValid),
        .funcCode(funcCode), .ctrlValid(ctrlValid), .ctrlWord(ctrlWord), .wrValid(wrValid), .wrData(wrData),
        .rdReq(rdReq), .rdBytes(rdBytes), .rdValid(rdValid), .rdData(rdData), .summaryStatus(summaryStatus),
        .selState(selState), .ppError(ppError), .unitError(unitError), .chanFault(chanFault),
        .procHalt(procHalt), .uncorrError(uncorrError), .envAlertPin(envAlertPin),
        .longDeadstartPin(longDeadstartPin), .barrelSwitchPin(barrelSwitchPin), .ppSwitchPin(ppSwitchPin),
        .registerSelectBits(registerSelectBits), .accReg(accReg), .progAddrReg(progAddrReg), .qReg(qReg),
        .kReg(kReg));

    iom_master u_iom_master (.clock(clock), .funcValid(funcValid), .funcCode(funcCode), .ctrlValid(ctrlValid),
        .ctrlWord(ctrlWord), .wrValid(wrValid), .wrData(wrData), .rdReq(rdReq), .rdBytes(rdBytes),
        .rdValid(rdValid), .rdData(rdData));

    // Hang guard
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            errorCnt++;
            finishTest();
        end
    end

    // ------------------------------------------------------------
    // Expectations
    // ------------------------------------------------------------
    function automatic int ppBit(input int k);
        return 3 + 8 * (k / 5) + (k % 5);
    endfunction : ppBit
    // Unit errors sit above the processor mask bits, so no mask hides them
    function automatic logic expSum();
        return |(expF1 & PP_BITS & ~expMask) | |(chanFault & CHAN_BITS & ~expMask) | |(expF1 & FS1_OTHER_BITS);
    endfunction : expSum
    function automatic logic [63:0] expReg(input logic [7:0] a, input logic [3:0] n);
        logic [63:0] r;
        logic [17:0] ir;
        r = 64'h0;
        ir = registerSelectBits[1] ? (registerSelectBits[0] ? kReg : qReg)
            : (registerSelectBits[0] ? progAddrReg : accReg);
        case (a)
            ADDR_SUMMARY: begin
                r[63] = envAlertPin;
                r[61] = uncorrError;
                for (int i = 0; i < 8; i++) begin
                    if (i == 7 || n > 4'h1) begin
                        r[8 * i + 3] = expSum();
                        r[8 * i + 4] = procHalt;
                    end
                end
            end
            ADDR_IDENT: r = {SERIAL_P, MODEL_P, TYPE_P, 32'h0};
            ADDR_OPTIONS: r = OPTS_P & OPT_BITS;
            ADDR_MASK: r = expMask;
            ADDR_STATUS: r = {ppSwitchPin, barrelSwitchPin, 2'b00, longDeadstartPin, ir, 38'h0};
            ADDR_FAULT1: r = expF1;
            default: r = 64'h0;
        endcase
        return r;
    endfunction : expReg

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checksDone++;
        if (got !== exp) begin
            errorCnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic checkReg(input logic [7:0] a, input logic [3:0] n);
        logic ok;
        logic [63:0] q;
        u_iom_master.select(FUNC_SELECT_A + 4'($urandom_range(1)), a, 8'($urandom));
        u_iom_master.read(n, ok, q);
        chk({63'h0, ok}, 64'h1);
        chk(q, expReg(a, n));
    endtask : checkReg
    task automatic writeReg(input logic [7:0] a, input logic [63:0] w);
        u_iom_master.select(FUNC_SELECT_B, a, 8'($urandom));
        u_iom_master.write(w);
        if (a == ADDR_MASK) expMask = w & MASK_BITS;
        if (a == ADDR_FAULT1) expF1 = expF1 & ~(w & FS1_BITS);
    endtask : writeReg
    // One-cycle error pulse; extra edge lets the summary flop follow
    task automatic pulse(input logic [19:0] pp, input logic [6:0] ue);
        @(posedge clock) #1;
        ppError = pp;
        unitError = ue;
        @(posedge clock) #1;
        ppError = 20'h0;
        unitError = 7'h0;
        for (int k = 0; k < 20; k++) if (pp[k]) expF1[ppBit(k)] = 1'b1;
        for (int j = 0; j < 7; j++) if (ue[j]) expF1[UNIT_ERR_POS[j]] = 1'b1;
        @(posedge clock) #1;
    endtask : pulse
    task automatic finishTest();
        $display("checks %0d errors %0d", checksDone, errorCnt);
        if (errorCnt == 0 && checksDone > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finishTest

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        seed = $urandom(94);
        {ppError, unitError, chanFault, procHalt, uncorrError} = '0;
        {envAlertPin, longDeadstartPin, barrelSwitchPin, ppSwitchPin, registerSelectBits} = '0;
        {accReg, progAddrReg, qReg, kReg} = '0;
        expMask = MASK_RESET;
        expF1 = FAULT1_RESET;
        repeat (8) @(posedge clock);
        #1;
        rst = 1'b0;
        chk({62'h0, selState}, {62'h0, ST_IDLE});
        chk({63'h0, summaryStatus}, 64'h0);
        // Nothing selected yet: read and control word are dropped
        u_iom_master.read(4'h1, v, d);
        chk({63'h0, v}, 64'h0);
        u_iom_master.send_ctrl({8'h00, ADDR_MASK});
        chk({62'h0, selState}, {62'h0, ST_IDLE});
        // Reset values, then random writes to every place, read-only ones too
        foreach (addrs[i]) checkReg(addrs[i], 4'h8);
        foreach (addrs[i]) begin
            writeReg(addrs[i], {$urandom, $urandom});
            checkReg(addrs[i], 4'h8);
        end
        // Each processor error: recorded, reaches summary until masked
        writeReg(ADDR_MASK, 64'h0);
        for (int k = 0; k < 20; k++) begin
            pulse(20'h1 << k, 7'h0);
            chk({63'h0, summaryStatus}, 64'h1);
            writeReg(ADDR_MASK, 64'h1 << ppBit(k));
            checkReg(ADDR_FAULT1, 4'h8);
            chk({63'h0, summaryStatus}, 64'h0);
            writeReg(ADDR_FAULT1, {$urandom, $urandom} | (64'h1 << ppBit(k)));
        end
        // Unit errors stay visible whatever the mask holds
        writeReg(ADDR_MASK, 64'hffffffff_ffffffff);
        for (int j = 0; j < 7; j++) begin
            pulse(20'($urandom), 7'h1 << j);
            chk({63'h0, summaryStatus}, 64'h1);
            checkReg(ADDR_FAULT1, 4'h8);
            writeReg(ADDR_FAULT1, 64'hffffffff_ffffffff);
        end
        // Reset in mid-run: mask and fault one go back to their reset values
        pulse(20'h1, 7'h1);
        rst = 1'b1;
        repeat (2) @(posedge clock);
        #1;
        rst = 1'b0;
        expMask = MASK_RESET;
        expF1 = FAULT1_RESET;
        chk({63'h0, summaryStatus}, 64'h0);
        checkReg(ADDR_MASK, 4'h8);
        checkReg(ADDR_FAULT1, 4'h8);
        // Status fields, selector codes and multi-byte summary reads
        for (int i = 0; i < 8; i++) begin
            writeReg(ADDR_MASK, {$urandom, $urandom});
            registerSelectBits = 2'(i);
            {accReg, progAddrReg, qReg, kReg} = {$urandom, $urandom, $urandom};
            {ppSwitchPin, barrelSwitchPin, longDeadstartPin, envAlertPin} = 7'($urandom);
            {procHalt, uncorrError} = 2'($urandom);
            chanFault = {$urandom, $urandom} & {$urandom, $urandom};
            repeat (5) @(posedge clock);
            #1;
            chk({63'h0, summaryStatus}, {63'h0, expSum()});
            checkReg(ADDR_STATUS, 4'h8);
            checkReg(ADDR_SUMMARY, 4'(i + 1));
        end
        // Other function codes drop selection
        u_iom_master.send_func(FUNC_SELECT_A);
        chk({62'h0, selState}, {62'h0, ST_WAIT_CTRL});
        u_iom_master.send_func(4'h3);
        u_iom_master.send_ctrl({8'h00, ADDR_IDENT});
        chk({62'h0, selState}, {62'h0, ST_IDLE});
        u_iom_master.read(4'h8, v, d);
        chk({63'h0, v}, 64'h0);
        finishTest();
    end
endmodule : tb_iom_maint_regs
`default_nettype wire
